//--- src/odts_cfg.svh
// Constants for the on-chip debug TAP support block
`ifndef ODTS_CFG_SVH
`define ODTS_CFG_SVH
// ****************************************
// Widths and TAP constants
// ****************************************
`define ODTS_IR_W       4
`define ODTS_DR_W       20
`define ODTS_PC_W       16
`define ODTS_CFG_W      9
`define ODTS_IRQ_W      3
`define ODTS_IR_CAPT    4'h1
`define ODTS_IR_RESET   4'hf
`define ODTS_TLR_COUNT  3'h5
// ****************************************
// Instruction opcodes
// ****************************************
`define ODTS_OP_PROG    4'h5
`define ODTS_OP_DBG0    4'h8
`define ODTS_OP_DBG1    4'h9
`define ODTS_OP_DBG2    4'ha
`define ODTS_OP_DBG3    4'hb
// ****************************************
// Data register lengths
// ****************************************
`define ODTS_LEN_BYP    5'h01
`define ODTS_LEN_BP     5'h13
`define ODTS_LEN_INJ    5'h10
`define ODTS_LEN_COMM   5'h09
`define ODTS_LEN_CFG    5'h09
`define ODTS_LEN_PROG   5'h02
// ****************************************
// Register map and fields
// ****************************************
`define ODTS_ADDR_MCU_STATUS_REGISTER 8'h00
`define ODTS_ADDR_COMM  8'h01
`define ODTS_ADDR_IST   8'h02
`define ODTS_ADDR_IMSK  8'h03
`define ODTS_ADDR_DST   8'h04
`define ODTS_TAPDIS_BIT 7
`define ODTS_DIRTY_BIT  7
`define ODTS_COMM_RST   8'h00
`define ODTS_CFG_ACC    0
`define ODTS_CFG_STEP   1
`define ODTS_CFG_FLOW   2
`define ODTS_CFG_MODE   3
`define ODTS_CFG_EN     4
`define ODTS_CFG_DBP    8
`define ODTS_IRQ_BRK    0
`define ODTS_IRQ_RD     1
`define ODTS_IRQ_INJ    2
`define ODTS_BP_SEL_DBP 3'h4
`endif

//--- src/odts_pkg.sv
// Types shared by the on-chip debug TAP support block
package odts_pkg;
`include "odts_cfg.svh"
    typedef enum logic [3:0] {
        TAP_TLR    = 4'h0, TAP_RTI    = 4'h1, TAP_SEL_DR = 4'h2, TAP_CAP_DR = 4'h3,
        TAP_SH_DR  = 4'h4, TAP_EX1_DR = 4'h5, TAP_PA_DR  = 4'h6, TAP_EX2_DR = 4'h7,
        TAP_UPD_DR = 4'h8, TAP_SEL_IR = 4'h9, TAP_CAP_IR = 4'ha, TAP_SH_IR  = 4'hb,
        TAP_EX1_IR = 4'hc, TAP_PA_IR  = 4'hd, TAP_EX2_IR = 4'he, TAP_UPD_IR = 4'hf
    } odts_tap_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } odts_bus_req_s;

    typedef struct packed {
        logic                   retire;
        logic [`ODTS_PC_W-1:0]  pc;
        logic                   flow_chg;
        logic                   dvalid;
        logic [`ODTS_PC_W-1:0]  daddr;
    } odts_cpu_obs_s;

    typedef struct packed {
        logic tap_enable_fuse;
        logic debug_enable_fuse;
        logic lock_bit_one;
        logic lock_bit_two;
    } odts_fuse_s;

    typedef struct packed {
        logic                   valid;
        logic [`ODTS_PC_W-1:0]  opcode;
    } odts_inj_s;

    typedef struct packed {
        odts_tap_e                   tap;
        logic [`ODTS_IR_W-1:0]       ir;
        logic [`ODTS_IR_W-1:0]       ir_sr;
        logic [`ODTS_DR_W-1:0]       dr_sr;
        logic                        tck_d;
        logic                        tdo;
        logic                        tdo_oe;
        logic [7:0]                  comm;
        logic                        dirty;
        logic [7:0]                  std_io;
        logic [7:0]                  mcu_status_register;
        logic [`ODTS_IRQ_W-1:0]      irq_st;
        logic [`ODTS_IRQ_W-1:0]      irq_mask;
        logic                        irq;
        logic [7:0]                  rdata;
        logic [`ODTS_CFG_W-1:0]      cfg;
        logic [3:0][`ODTS_PC_W-1:0]  bp;
        logic [`ODTS_PC_W-1:0]       dbp;
        logic                        brk;
        logic                        inj_v;
        logic [`ODTS_PC_W-1:0]       inj_op;
        logic                        erased;
        logic                        fuse_prog;
        logic                        erase;
    } odts_state_s;
endpackage

//--- src/odts_sync.sv
// Two-stage synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
module odts_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } odts_sync_s;

    odts_sync_s s_ff;
    odts_sync_s nxt_s;

    always_comb begin
        nxt_s      = s_ff;
        nxt_s.meta = d;
        nxt_s.sync = s_ff.meta;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign q = s_ff.sync;
endmodule

//--- src/odts_top.sv
// On-chip debug support behind the test access port
// Summary of operation
// [RL1] Five TCK periods with TMS high always bring the TAP to Test-Logic-Reset.
// [RL2] Opcodes 8, 9, a and b are decoded as the four private debug access instructions.
// [RL3] Breaks on flow change, single step, two program and two combined break points.
// [RL4] Break resources form four program plus one data, or two program plus one range.
// [RL5] Injected CPU instructions come from the scan chain, results return via the comm register.
// [RL6] Debug works only with both fuses programmed and no lock bit set.
// [RL7] A CPU write of the comm register sets the dirty flag.
// [RL8] A CPU read of the comm register returns stored bits 6..0 and the dirty flag as bit 7.
// [RL9] The debugger clears the dirty flag after reading the byte.
// [RL10] The shared address reaches the comm register only with the debug fuse and access enable.
// [RL11] The TAP works only with the TAP fuse programmed and the disable bit clear.
// [RL12] Programming of memories, fuses and lock bits needs only the four TAP pins.
// [RL13] With a lock bit set the debug fuse cannot be programmed until after a chip erase.
// [RL14] Every comm register bit is readable and writable and resets to zero.
// [RL15] The TAP starts in Test-Logic-Reset and shift registers move LSB first.
// [RL16] A CPU write while dirty overwrites the byte and keeps the flag set.
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "odts_cfg.svh"
module odts_top (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    // TAP pins
    input  wire logic                    tck,
    input  wire logic                    tms,
    input  wire logic                    tdi,
    output logic                         tdo,
    output logic                         tdo_oe,
    // Fuses and lock bits
    input  wire odts_pkg::odts_fuse_s    fuse,
    // Register port
    input  wire odts_pkg::odts_bus_req_s bus,
    output logic [7:0]                   rdata,
    // CPU debug side
    input  wire odts_pkg::odts_cpu_obs_s obs,
    output logic                         brk_req,
    output odts_pkg::odts_inj_s          inj,
    // Programming requests
    output logic                         fuse_prog_req,
    output logic                         chip_erase_req,
    // Interrupt
    output logic                         irq
);
    import odts_pkg::*;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    odts_state_s s;
    odts_state_s n;
    odts_fuse_s  fuse_s;
    logic        tck_s;
    logic        tms_s;
    logic        tdi_s;

    odts_sync #(.W(7)) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     ({tck, tms, tdi, fuse}),
        .q     ({tck_s, tms_s, tdi_s, fuse_s})
    );

    // ****************************************
    // TAP state transitions
    // ****************************************
    function automatic odts_tap_e tap_next(input odts_tap_e st, input logic m);
        case (st)
            TAP_TLR:    tap_next = m ? TAP_TLR    : TAP_RTI;
            TAP_RTI:    tap_next = m ? TAP_SEL_DR : TAP_RTI;
            TAP_SEL_DR: tap_next = m ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR:  tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: tap_next = m ? TAP_UPD_DR : TAP_PA_DR;
            TAP_PA_DR:  tap_next = m ? TAP_EX2_DR : TAP_PA_DR;
            TAP_EX2_DR: tap_next = m ? TAP_UPD_DR : TAP_SH_DR;
            TAP_UPD_DR: tap_next = m ? TAP_SEL_DR : TAP_RTI;
            TAP_SEL_IR: tap_next = m ? TAP_TLR    : TAP_CAP_IR;
            TAP_CAP_IR: tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR:  tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: tap_next = m ? TAP_UPD_IR : TAP_PA_IR;
            TAP_PA_IR:  tap_next = m ? TAP_EX2_IR : TAP_PA_IR;
            TAP_EX2_IR: tap_next = m ? TAP_UPD_IR : TAP_SH_IR;
            TAP_UPD_IR: tap_next = m ? TAP_SEL_DR : TAP_RTI;
            default:    tap_next = TAP_TLR;
        endcase
    endfunction

    // ****************************************
    // Enables and decode
    // ****************************************
    logic                   tap_en;
    logic                   dbg_en;
    logic                   tck_rise;
    logic                   tck_fall;
    logic                   comm_sel;
    logic                   prog_ok;
    logic [`ODTS_IR_W-1:0]  ir_eff;
    logic [4:0]             dr_len;
    logic [`ODTS_DR_W-1:0]  dr_cap;
    logic [`ODTS_DR_W-1:0]  dr_upd;
    logic [3:0]             pm_hit;
    logic                   rng_hit;
    logic                   d_hit;
    logic                   bp_hit;
    logic                   brk_hit;
    logic [`ODTS_IRQ_W-1:0] irq_set;

    assign tap_en   = fuse_s.tap_enable_fuse & ~s.mcu_status_register[`ODTS_TAPDIS_BIT]; // RL11
    assign dbg_en   = fuse_s.tap_enable_fuse & fuse_s.debug_enable_fuse
                    & ~(fuse_s.lock_bit_one | fuse_s.lock_bit_two); // RL6
    assign tck_rise = tck_s & ~s.tck_d;
    assign tck_fall = ~tck_s & s.tck_d;
    // Lock bits close the comm channel too, else it would be a back door
    assign comm_sel = dbg_en & s.cfg[`ODTS_CFG_ACC]; // RL10 RL6
    assign prog_ok  = ~(fuse_s.lock_bit_one | fuse_s.lock_bit_two) | s.erased; // RL13

    // Private opcodes collapse to bypass while debug is locked out
    always_comb begin
        ir_eff = s.ir;
        if (!dbg_en && s.ir[3] && !s.ir[2]) begin
            ir_eff = `ODTS_IR_RESET; // RL6
        end
        case (ir_eff) // RL2
            `ODTS_OP_DBG0: dr_len = `ODTS_LEN_BP;
            `ODTS_OP_DBG1: dr_len = `ODTS_LEN_INJ;
            `ODTS_OP_DBG2: dr_len = `ODTS_LEN_COMM;
            `ODTS_OP_DBG3: dr_len = `ODTS_LEN_CFG;
            `ODTS_OP_PROG: dr_len = `ODTS_LEN_PROG;
            default:       dr_len = `ODTS_LEN_BYP;
        endcase
        case (ir_eff)
            `ODTS_OP_DBG2: dr_cap = `ODTS_DR_W'({s.dirty, s.comm});
            `ODTS_OP_DBG3: dr_cap = `ODTS_DR_W'(s.cfg);
            `ODTS_OP_PROG: dr_cap = `ODTS_DR_W'({s.erased, prog_ok});
            default:       dr_cap = '0;
        endcase
        // Data enters at the top, so the selected length ends at the low bits
        dr_upd = s.dr_sr >> (5'(`ODTS_DR_W) - dr_len); // RL15
    end

    // ****************************************
    // Break point unit
    // ****************************************
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pm_hit[i] = s.cfg[`ODTS_CFG_EN + i] & (obs.pc == s.bp[i]); // RL3
        end
        rng_hit = s.cfg[`ODTS_CFG_EN + 2] & ((obs.pc & s.bp[3]) == (s.bp[2] & s.bp[3]));
        d_hit   = s.cfg[`ODTS_CFG_DBP] & obs.dvalid & (obs.daddr == s.dbp);
        if (s.cfg[`ODTS_CFG_MODE]) begin
            bp_hit = obs.retire & (pm_hit[0] | pm_hit[1] | rng_hit); // RL4
        end else begin
            bp_hit = (obs.retire & (|pm_hit)) | d_hit; // RL4
        end
        brk_hit = dbg_en & (bp_hit
                | (obs.retire & s.cfg[`ODTS_CFG_STEP])
                | (obs.retire & obs.flow_chg & s.cfg[`ODTS_CFG_FLOW])); // RL3
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        n           = s;
        n.tck_d     = tck_s;
        n.brk       = brk_hit;
        n.inj_v     = 1'b0;
        n.fuse_prog = 1'b0;
        n.erase     = 1'b0;
        n.rdata     = 8'h00;
        irq_set     = '0;
        irq_set[`ODTS_IRQ_BRK] = brk_hit;
        if (!tap_en) begin
            n.tap    = TAP_TLR; // RL11
            n.ir     = `ODTS_IR_RESET;
            n.tdo_oe = 1'b0;
        end else if (tck_rise) begin
            n.tap = tap_next(s.tap, tms_s); // RL1
            case (s.tap)
                TAP_TLR: begin
                    n.ir = `ODTS_IR_RESET; // RL15
                end
                TAP_CAP_IR: begin
                    n.ir_sr = `ODTS_IR_CAPT;
                end
                TAP_SH_IR: begin
                    n.ir_sr = {tdi_s, s.ir_sr[`ODTS_IR_W-1:1]}; // RL15
                end
                TAP_UPD_IR: begin
                    n.ir = s.ir_sr; // RL2
                end
                TAP_CAP_DR: begin
                    n.dr_sr = dr_cap;
                end
                TAP_SH_DR: begin
                    n.dr_sr = {tdi_s, s.dr_sr[`ODTS_DR_W-1:1]}; // RL15
                end
                TAP_UPD_DR: begin
                    case (ir_eff)
                        `ODTS_OP_DBG0: begin
                            if (dr_upd[18:16] == `ODTS_BP_SEL_DBP) begin
                                n.dbp = dr_upd[15:0]; // RL4
                            end else if (!dr_upd[18]) begin
                                n.bp[dr_upd[17:16]] = dr_upd[15:0]; // RL3
                            end
                        end
                        `ODTS_OP_DBG1: begin
                            n.inj_v  = 1'b1; // RL5
                            n.inj_op = dr_upd[15:0];
                            irq_set[`ODTS_IRQ_INJ] = 1'b1;
                        end
                        `ODTS_OP_DBG2: begin
                            if (dr_upd[8]) begin
                                n.dirty = 1'b0; // RL9
                                irq_set[`ODTS_IRQ_RD] = 1'b1;
                            end
                        end
                        `ODTS_OP_DBG3: begin
                            n.cfg = dr_upd[`ODTS_CFG_W-1:0];
                        end
                        `ODTS_OP_PROG: begin
                            // Erase unlocks the debug fuse only from the next request on
                            if (dr_upd[0]) begin
                                n.erase  = 1'b1; // RL12
                                n.erased = 1'b1;
                            end
                            n.fuse_prog = dr_upd[1] & prog_ok; // RL13
                        end
                        default: ;
                    endcase
                end
                default: ;
            endcase
        end else if (tck_fall) begin
            // Output changes on the falling edge so the far end samples mid-bit
            n.tdo    = (s.tap == TAP_SH_IR) ? s.ir_sr[0] : s.dr_sr[0]; // RL15
            n.tdo_oe = (s.tap == TAP_SH_IR) | (s.tap == TAP_SH_DR);
        end
        // Register port, after the TAP so a CPU set beats a debugger clear
        if (bus.wr) begin
            case (bus.addr)
                `ODTS_ADDR_MCU_STATUS_REGISTER: n.mcu_status_register = bus.wdata;
                `ODTS_ADDR_COMM: begin
                    if (comm_sel) begin
                        n.comm  = bus.wdata; // RL16
                        n.dirty = 1'b1; // RL7
                    end else begin
                        n.std_io = bus.wdata; // RL10
                    end
                end
                `ODTS_ADDR_IST:  n.irq_st = s.irq_st & ~bus.wdata[`ODTS_IRQ_W-1:0];
                `ODTS_ADDR_IMSK: n.irq_mask = bus.wdata[`ODTS_IRQ_W-1:0];
                default: ;
            endcase
        end
        if (bus.rd) begin
            case (bus.addr)
                `ODTS_ADDR_MCU_STATUS_REGISTER: n.rdata = s.mcu_status_register;
                `ODTS_ADDR_COMM: begin
                    n.rdata = comm_sel ? {s.dirty, s.comm[6:0]} : s.std_io; // RL8
                end
                `ODTS_ADDR_IST:  n.rdata = 8'(s.irq_st);
                `ODTS_ADDR_IMSK: n.rdata = 8'(s.irq_mask);
                `ODTS_ADDR_DST:  n.rdata = {tap_en, dbg_en, s.erased, s.dirty, s.tap};
                default:         n.rdata = 8'h00;
            endcase
        end
        n.irq_st = n.irq_st | irq_set;
        n.irq    = |(n.irq_st & s.irq_mask);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s       <= '0;
            s.tap   <= TAP_TLR; // RL15
            s.ir    <= `ODTS_IR_RESET;
            s.comm  <= `ODTS_COMM_RST; // RL14
        end else begin
            s <= n;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign tdo            = s.tdo;
    assign tdo_oe         = s.tdo_oe;
    assign rdata          = s.rdata;
    assign brk_req        = s.brk;
    assign inj            = {s.inj_v, s.inj_op};
    assign fuse_prog_req  = s.fuse_prog;
    assign chip_erase_req = s.erase;
    assign irq            = s.irq;

    // ****************************************
    // Assertions
    // ****************************************
    logic [2:0] tms_cnt;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tms_cnt <= 3'h0;
        end else if (!tap_en || (tck_rise && !tms_s)) begin
            tms_cnt <= 3'h0;
        end else if (tck_rise && tms_cnt != `ODTS_TLR_COUNT) begin
            tms_cnt <= tms_cnt + 3'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_tms_reset;
        tms_cnt == `ODTS_TLR_COUNT |-> s.tap == TAP_TLR;
    endproperty
    a_tms_reset: assert property (p_tms_reset) // RL1
        else $error("TAP not in reset after five TMS high periods");

    property p_dirty_set;
        bus.wr && bus.addr == `ODTS_ADDR_COMM && comm_sel |=> s.dirty && s.comm == $past(bus.wdata);
    endproperty
    a_dirty_set: assert property (p_dirty_set) // RL7
        else $error("Comm write did not set dirty flag");

    property p_comm_read;
        bus.rd && bus.addr == `ODTS_ADDR_COMM && comm_sel
            |=> rdata == {$past(s.dirty), $past(s.comm[6:0])};
    endproperty
    a_comm_read: assert property (p_comm_read) // RL8
        else $error("Comm read data wrong");

    property p_brk_gate;
        brk_req |-> $past(dbg_en);
    endproperty
    a_brk_gate: assert property (p_brk_gate) // RL6
        else $error("Break raised while debug disabled");

    property p_tap_off;
        !tap_en |=> s.tap == TAP_TLR ##1 !tdo_oe;
    endproperty
    a_tap_off: assert property (p_tap_off) // RL11
        else $error("TAP active while disabled");

    property p_fuse_lock;
        fuse_prog_req |-> $past(prog_ok);
    endproperty
    a_fuse_lock: assert property (p_fuse_lock) // RL13
        else $error("Debug fuse programmed while locked");

    property p_std_io;
        bus.wr && bus.addr == `ODTS_ADDR_COMM && !comm_sel
            |=> $stable(s.comm) && s.std_io == $past(bus.wdata);
    endproperty
    a_std_io: assert property (p_std_io) // RL10
        else $error("Shared address routed wrongly");

    property p_overwrite;
        s.dirty && bus.wr && bus.addr == `ODTS_ADDR_COMM && comm_sel |=> s.dirty [*2];
    endproperty
    a_overwrite: assert property (p_overwrite) // RL16
        else $error("Dirty flag lost on overwrite");

    property p_inject;
        tck_rise && s.tap == TAP_UPD_DR && ir_eff == `ODTS_OP_DBG1 |=> inj.valid ##1 !inj.valid;
    endproperty
    a_inject: assert property (p_inject) // RL5
        else $error("Injected instruction not issued as one pulse");

    c_inject: cover property (inj.valid);
    c_brk: cover property (brk_req && s.cfg[`ODTS_CFG_MODE]);
    c_clear: cover property (s.dirty ##1 !s.dirty);
    c_erase: cover property (chip_erase_req ##[1:1000] fuse_prog_req);
endmodule

//--- dv/odts_dbg_model.sv
// Model of the external debugger driving the test access port
`timescale 1ns/1ps
module odts_dbg_model (
    // Clock
    input  wire logic clk,
    // Test access port
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo,
    input  wire logic tdo_oe
);
    // ****************************************
    // Pin levels and link clock
    // ****************************************
    wire tdo_line = tdo_oe ? tdo : 1'b1; // Pull-up holds a released line high
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end
    // Clock parks low between frames; 12 low plus 13 high cycles give 125 ns
    task automatic pulse(input logic m, input logic d, output logic o);
        @(posedge clk);
        tms <= m;
        tdi <= d;
        repeat (10) @(posedge clk);
        o = tdo_line;
        @(posedge clk);
        tck <= 1'b1;
        repeat (13) @(posedge clk);
        tck <= 1'b0;
    endtask
    task automatic tlr();
        logic o;
        repeat (5) pulse(1'b1, 1'b1, o);
        pulse(1'b0, 1'b1, o);
    endtask
    // Run-Test/Idle to a shift and back, LSB first
    task automatic scan(input logic ir, input int n, input logic [19:0] din,
                        output logic [19:0] dout);
        logic o;
        dout = '0;
        pulse(1'b1, 1'b1, o);
        if (ir) pulse(1'b1, 1'b1, o);
        pulse(1'b0, 1'b1, o);
        pulse(1'b0, 1'b1, o);
        for (int i = 0; i < n; i++) begin
            pulse(i == n - 1, din[i], o);
            dout[i] = o;
        end
        pulse(1'b1, 1'b1, o);
        pulse(1'b0, 1'b1, o);
    endtask
endmodule

//--- dv/onchip_debug_tap_support_test.sv
// Self-checking bench for the on-chip debug TAP support block
`timescale 1ns/1ps
module onchip_debug_tap_support_test;
    import odts_pkg::*;
    // ****************************************
    // Signals, design and debugger
    // ****************************************
    logic          clk = 1'b0;
    logic          rst_n = 1'b0;
    logic          tck, tms, tdi, tdo, tdo_oe, brk_req, irq, fuse_prog_req, chip_erase_req;
    logic [7:0]    rdata, rv, m_comm;
    logic          m_dirty;
    logic [19:0]   so;
    logic [15:0]   op, pc;
    logic [31:0]   seed = 32'h8ae7ff1e;
    odts_fuse_s    fuse = 4'b1100;
    odts_bus_req_s bus = '0;
    odts_cpu_obs_s obs = '0;
    odts_inj_s     inj;
    int            fail_count = 0, n_tests = 0, n_brk = 0, n_inj = 0, n_prog = 0, n_ers = 0;
    always #2.5 clk = ~clk;
    odts_top i_dut (.clk(clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_oe(tdo_oe), .fuse(fuse), .bus(bus), .rdata(rdata), .obs(obs),
        .brk_req(brk_req), .inj(inj), .fuse_prog_req(fuse_prog_req),
        .chip_erase_req(chip_erase_req), .irq(irq));
    odts_dbg_model i_dbg (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_oe(tdo_oe));
    // Pulse outputs are counted, so no wait hangs on a missing pulse
    always @(posedge clk) begin
        n_brk <= n_brk + brk_req;
        n_inj <= n_inj + inj.valid;
        n_prog <= n_prog + fuse_prog_req;
        n_ers <= n_ers + chip_erase_req;
    end
    // ****************************************
    // Tasks
    // ****************************************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk) bus <= '0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk) bus <= '0;
        #1 rv = rdata;
    endtask
    task automatic rdc();
        rd(8'h01);
        chk(rv, {m_dirty, m_comm[6:0]});
    endtask
    task automatic ir(input logic [3:0] c);
        i_dbg.scan(1'b1, 4, {16'h0, c}, so);
        chk(so[3:0], 4'h1);
    endtask
    task automatic hit(input logic [15:0] p);
        @(posedge clk) obs <= '{1'b1, p, 1'b0, 1'b0, 16'h0};
        @(posedge clk) obs <= '0;
        repeat (3) @(posedge clk);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        i_dbg.tlr();
        ir(4'hb);
        i_dbg.scan(1'b0, 9, 20'h00011, so);
        m_comm = 8'h00;
        m_dirty = 1'b0;
        rdc();
        // Second write lands while still dirty
        for (int k = 0; k < 2; k++) begin
            m_comm = 8'(rnd());
            wr(8'h01, m_comm);
            m_dirty = 1'b1;
            rdc();
        end
        $display("test comm write done");
        ir(4'ha);
        i_dbg.scan(1'b0, 9, 20'h00100, so);
        chk(so[8:0], {m_dirty, m_comm});
        m_dirty = 1'b0;
        rdc();
        rd(8'h02);
        chk(rv, 8'h02);
        chk(irq, 1'b0);
        wr(8'h03, 8'h07);
        repeat (3) @(posedge clk);
        #1 chk(irq, 1'b1);
        wr(8'h02, 8'h02);
        repeat (3) @(posedge clk);
        #1 chk(irq, 1'b0);
        $display("test dirty clear done");
        op = 16'(rnd());
        ir(4'h9);
        i_dbg.scan(1'b0, 16, {4'h0, op}, so);
        chk(n_inj, 1);
        chk(inj.opcode, op);
        pc = 16'(rnd());
        ir(4'h8);
        i_dbg.scan(1'b0, 19, {4'h0, pc}, so);
        hit(pc ^ 16'h0001);
        chk(n_brk, 0);
        hit(pc);
        chk(n_brk, 1);
        // Range mode: bp2 value, bp3 mask on the high byte
        i_dbg.scan(1'b0, 19, {1'b0, 3'h2, pc}, so);
        i_dbg.scan(1'b0, 19, {1'b0, 3'h3, 16'hff00}, so);
        ir(4'hb);
        i_dbg.scan(1'b0, 9, 20'h00049, so);
        hit(pc ^ 16'h0010);
        chk(n_brk, 2);
        hit(pc ^ 16'h0100);
        chk(n_brk, 2);
        i_dbg.scan(1'b0, 9, 20'h00003, so);
        hit(pc ^ 16'h0100);
        chk(n_brk, 3);
        $display("test inject and break done");
        fuse <= 4'b1110;
        repeat (4) @(posedge clk);
        wr(8'h01, 8'h5a);
        rd(8'h01);
        chk(rv, 8'h5a);
        hit(pc);
        chk(n_brk, 3);
        i_dbg.tlr();
        ir(4'h5);
        // Fuse request refused until an erase has been done
        for (int k = 0; k < 3; k++) begin
            i_dbg.scan(1'b0, 2, (k == 1) ? 20'h1 : 20'h2, so);
            chk(n_prog, k / 2);
            chk(n_ers, k > 0);
        end
        $display("test lock done");
        wr(8'h00, 8'h80);
        i_dbg.scan(1'b1, 4, 20'h0000b, so);
        chk(so[3:0], 4'hf);
        $display("test tap disable done");
        tally_and_finish();
    end
endmodule
